// *** pulse_timer_cfg.svh ***
// register offsets, field positions, reset values and timing counts for the pulse timer
// assumes inclusion by bare name from the package and the testbench
`ifndef PULSE_TIMER_CFG_SVH
`define PULSE_TIMER_CFG_SVH

// ==========================================
// register offsets
`define ADDR_CTRL_ONE   4'h0
`define ADDR_CTRL_TWO   4'h1
`define ADDR_CTRL_THREE 4'h2
`define ADDR_PERIOD     4'h3
`define ADDR_CMP_ONE    4'h4
`define ADDR_CMP_TWO    4'h5

// ==========================================
// field positions
`define F_INIT_ONE      0
`define F_INIT_TWO      1
`define F_EMG_EN        0
`define F_EMG_REL       1
`define F_RUN           0
`define F_STM_LO        1
`define F_STM_HI        2
`define F_EMG_FLAG      3
`define F_BUSY          4

// ==========================================
// reset values and encodings
`define RST_INIT        2'h0
`define RST_EMG_EN      1'h0
`define RST_STM         2'h0
`define RST_PERIOD      10'h3ff
`define RST_CMP         10'h000
`define STM_INIT        2'h0
`define STM_HOLD        2'h1
`define STM_END         2'h2

// ==========================================
// timing: low time on the emergency pin and response, in gear clock periods
`define EMG_MIN_LOW_GCK 4
`define EMG_RESP_GCK    4
`define EMG_FILT_CYC    (`EMG_MIN_LOW_GCK - 1)

`endif

// *** pulse_timer_pkg.sv ***
// types shared by the pulse timer modules
// assumes the cfg header sits in the include path
package pulse_timer_pkg;
   `include "pulse_timer_cfg.svh"

   // ==========================================
   // counter sequencing states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT_TRIG,
      ST_COUNT
   } timer_state_t;

   typedef logic [1:0] stop_mode_t;
endpackage

// *** emg_detect.sv ***
// low-level filter for the active-low emergency stop pin
// assumes the pin is synchronous to the clock; a stop needs a low lasting SAMPLES cycles
`timescale 1ns/1ps
module emg_detect #(
   parameter int SAMPLES = 3
) (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic pin_b,
   output logic      low_det
);
   logic [SAMPLES-1:0] smp_r;
   logic [SAMPLES-1:0] smp_nxt;

   // ==========================================
   // sample shift, one bit per clock
   always_comb begin
      smp_nxt = {smp_r[SAMPLES-2:0], pin_b};
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         smp_r <= {SAMPLES{1'b1}};
      end else begin
         smp_r <= smp_nxt;
      end
   end

   // low seen on every sample
   assign low_det = ~|smp_r;
endmodule

// *** pulse_timer_emergency_stop.sv ***
// ten-bit pulse timer: two pulse outputs, period and trigger events, emergency output stop
// assumes SYS_CLK is the high-frequency gear clock and all inputs are synchronous to it
// Function
// - period event on command start and wrap
// - period event continues during emergency stop
// - start at stop level waits for trigger
// - emergency event whenever outputs are stopped
// - emergency enable gates pin, resets zero
// - accepted low forces initial levels, event
// - emergency stops outputs only, counter runs
// - pin valid only when port is input
// - pin sampled only while fast clock runs
// - emergency flag set on stop
// - release during low re-enters stop, event
// - every accepted stop gives an event
// - release works only when stopped, mode 00
// - no restart in emergency; software reprograms
// - outputs initialised within four clocks
// - leaving normal/idle modes resets timer
// - debug break freezes, drives initial levels
// - initial bit selects polarity per output
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module pulse_timer_emergency_stop
   import pulse_timer_pkg::*;
#(
   parameter int CW = 10,
   parameter int DW = 16
) (
   input  wire logic          SYS_CLK,
   input  wire logic          RST_B,
   input  wire logic [3:0]    ADDR,
   input  wire logic [DW-1:0] WR_DATA,
   input  wire logic          WR_STB,
   input  wire logic          RD_STB,
   output logic      [DW-1:0] RD_DATA,
   input  wire logic          TRIG_PIN,
   input  wire logic          EMG_PIN_B,
   input  wire logic          EMG_PORT_IS_INPUT,
   input  wire logic          HF_CLK_RUN,
   input  wire logic          MODE_RUN_OK,
   input  wire logic          DBG_BREAK,
   input  wire logic          DBG_KEEP_RUN,
   output logic [1:0]         PULSE_OUT,
   output logic               PERIOD_IRQ,
   output logic               TRIG_IRQ,
   output logic               EMG_IRQ
);
   // register state
   logic [1:0]    init_r,   init_nxt;
   logic          emg_en_r, emg_en_nxt;
   logic          run_r,    run_nxt;
   stop_mode_t    stm_r,    stm_nxt;
   logic [CW-1:0] period_r, period_nxt;
   logic [CW-1:0] cmp_r [2];
   logic [CW-1:0] cmp_nxt [2];
   logic [DW-1:0] rd_r,     rd_nxt;
   // emergency state
   logic          emg_r,    emg_nxt;
   logic          eirq_r,   eirq_nxt;
   logic          low_det;
   logic          emg_accept;
   logic          rel_req;
   // timer state
   timer_state_t  st_r,     st_nxt;
   logic [CW-1:0] cnt_r,    cnt_nxt;
   logic          run_q_r,  run_q_nxt;
   logic          trig_q_r, trig_q_nxt;
   logic          hold_r,   hold_nxt;
   logic          pirq_r,   pirq_nxt;
   logic          tirq_r,   tirq_nxt;
   logic          freeze;
   logic          trig_rise;
   // outputs
   logic [1:0]    out_r,    out_nxt;
   logic [1:0]    wave;
   logic [1:0]    nxt_wave;

   // ==========================================
   // register file
   always_comb begin
      init_nxt   = init_r;
      emg_en_nxt = emg_en_r;
      run_nxt    = run_r;
      stm_nxt    = stm_r;
      period_nxt = period_r;
      cmp_nxt    = cmp_r;
      rd_nxt     = '0;
      rel_req    = 1'b0;
      if (WR_STB) begin
         case (ADDR)
            `ADDR_CTRL_ONE: begin
               init_nxt = WR_DATA[1:0];
            end
            `ADDR_CTRL_TWO: begin
               emg_en_nxt = WR_DATA[`F_EMG_EN];
               rel_req    = WR_DATA[`F_EMG_REL];
            end
            `ADDR_CTRL_THREE: begin
               run_nxt = WR_DATA[`F_RUN];
               stm_nxt = WR_DATA[`F_STM_HI:`F_STM_LO];
            end
            `ADDR_PERIOD: begin
               period_nxt = WR_DATA[CW-1:0];
            end
            `ADDR_CMP_ONE: begin
               cmp_nxt[0] = WR_DATA[CW-1:0];
            end
            `ADDR_CMP_TWO: begin
               cmp_nxt[1] = WR_DATA[CW-1:0];
            end
            default: begin
               rel_req = 1'b0;
            end
         endcase
      end
      // low-power mode entry clears the run request
      if (!MODE_RUN_OK) begin
         run_nxt = 1'b0;
      end
      if (RD_STB) begin
         case (ADDR)
            `ADDR_CTRL_ONE:   rd_nxt = {{(DW-2){1'b0}}, init_r};
            `ADDR_CTRL_TWO:   rd_nxt = {{(DW-1){1'b0}}, emg_en_r};
            `ADDR_CTRL_THREE: rd_nxt = {{(DW-5){1'b0}}, (st_r != ST_IDLE), emg_r, stm_r, run_r};
            `ADDR_PERIOD:     rd_nxt = {{(DW-CW){1'b0}}, period_r};
            `ADDR_CMP_ONE:    rd_nxt = {{(DW-CW){1'b0}}, cmp_r[0]};
            `ADDR_CMP_TWO:    rd_nxt = {{(DW-CW){1'b0}}, cmp_r[1]};
            default:          rd_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         init_r   <= `RST_INIT;
         emg_en_r <= `RST_EMG_EN;
         run_r    <= 1'b0;
         stm_r    <= `RST_STM;
         period_r <= `RST_PERIOD;
         cmp_r[0] <= `RST_CMP;
         cmp_r[1] <= `RST_CMP;
         rd_r     <= '0;
      end else begin
         init_r   <= init_nxt;
         emg_en_r <= emg_en_nxt;
         run_r    <= run_nxt;
         stm_r    <= stm_nxt;
         period_r <= period_nxt;
         cmp_r    <= cmp_nxt;
         rd_r     <= rd_nxt;
      end
   end

   // ==========================================
   // emergency stop
   emg_detect #(
      .SAMPLES (`EMG_FILT_CYC)
   ) u_emg_detect (
      .clk     (SYS_CLK),
      .rst_b   (RST_B),
      .pin_b   (EMG_PIN_B),
      .low_det (low_det)
   );

   // accepted only when enabled, port is input and fast clock runs
   assign emg_accept = low_det & emg_en_r & EMG_PORT_IS_INPUT & HF_CLK_RUN;

   always_comb begin
      emg_nxt  = emg_r;
      eirq_nxt = 1'b0;
      // release only while stopped with initialising stop mode
      if (rel_req && !run_r && stm_r == `STM_INIT) begin
         emg_nxt = 1'b0;
         if (emg_accept) begin
            emg_nxt  = 1'b1;
            eirq_nxt = 1'b1;
         end
      end else if (emg_accept && !emg_r) begin
         emg_nxt  = 1'b1;
         eirq_nxt = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         emg_r  <= 1'b0;
         eirq_r <= 1'b0;
      end else begin
         emg_r  <= emg_nxt;
         eirq_r <= eirq_nxt;
      end
   end

   // ==========================================
   // counter sequencing
   assign freeze    = DBG_BREAK & ~DBG_KEEP_RUN;
   assign trig_rise = TRIG_PIN & ~trig_q_r;

   always_comb begin
      st_nxt     = st_r;
      cnt_nxt    = cnt_r;
      hold_nxt   = hold_r;
      pirq_nxt   = 1'b0;
      tirq_nxt   = 1'b0;
      run_q_nxt  = run_r;
      trig_q_nxt = TRIG_PIN;
      case (st_r)
         ST_IDLE: begin
            // command start refused during emergency stop
            if (run_r && !run_q_r && !emg_r && MODE_RUN_OK) begin
               hold_nxt = 1'b0;
               cnt_nxt  = '0;
               if (!TRIG_PIN) begin
                  st_nxt = ST_WAIT_TRIG;
               end else begin
                  st_nxt   = ST_COUNT;
                  pirq_nxt = 1'b1;
               end
            end
         end
         ST_WAIT_TRIG: begin
            if (!run_r) begin
               st_nxt = ST_IDLE;
            end else if (trig_rise && !emg_r) begin
               st_nxt   = ST_COUNT;
               tirq_nxt = 1'b1;
            end
         end
         ST_COUNT: begin
            if (!run_r && stm_r != `STM_END) begin
               st_nxt   = ST_IDLE;
               cnt_nxt  = '0;
               hold_nxt = (stm_r == `STM_HOLD);
            end else if (!freeze) begin
               // counter keeps running through an emergency stop
               if (cnt_r == period_r) begin
                  cnt_nxt  = '0;
                  pirq_nxt = 1'b1;
                  if (!run_r) begin
                     st_nxt = ST_IDLE;
                  end
               end else begin
                  cnt_nxt = cnt_r + 1'b1;
               end
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
      // low-power mode entry initialises and halts
      if (!MODE_RUN_OK) begin
         st_nxt   = ST_IDLE;
         cnt_nxt  = '0;
         hold_nxt = 1'b0;
         pirq_nxt = 1'b0;
         tirq_nxt = 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         st_r     <= ST_IDLE;
         cnt_r    <= '0;
         hold_r   <= 1'b0;
         pirq_r   <= 1'b0;
         tirq_r   <= 1'b0;
         run_q_r  <= 1'b0;
         trig_q_r <= 1'b1;
      end else begin
         st_r     <= st_nxt;
         cnt_r    <= cnt_nxt;
         hold_r   <= hold_nxt;
         pirq_r   <= pirq_nxt;
         tirq_r   <= tirq_nxt;
         run_q_r  <= run_q_nxt;
         trig_q_r <= trig_q_nxt;
      end
   end

   // ==========================================
   // pulse outputs, one compare per output
   for (genvar i = 0; i < 2; i++) begin : g_wave
      assign wave[i]     = (cnt_nxt >= cmp_r[i]);
      assign nxt_wave[i] = init_r[i] ^ wave[i];
   end

   always_comb begin
      if (emg_nxt || freeze) begin
         out_nxt = init_r;
      end else if (st_nxt == ST_COUNT) begin
         out_nxt = nxt_wave;
      end else if (hold_nxt) begin
         out_nxt = out_r;
      end else begin
         out_nxt = init_r;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         out_r <= `RST_INIT;
      end else begin
         out_r <= out_nxt;
      end
   end

   assign PULSE_OUT  = out_r;
   assign PERIOD_IRQ = pirq_r;
   assign TRIG_IRQ   = tirq_r;
   assign EMG_IRQ    = eirq_r;
   assign RD_DATA    = rd_r;

   // ==========================================
   // checks
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);

   a_emg_out_init: assert property (emg_r |-> out_r == init_r)
      else $error("outputs not at initial levels during emergency stop");
   a_emg_resp_time: assert property ((!EMG_PIN_B && emg_en_r && EMG_PORT_IS_INPUT && HF_CLK_RUN) [*4]
      |=> emg_r && out_r == init_r)
      else $error("emergency response slower than four clocks");
   a_emg_irq_set: assert property ($rose(emg_r) |-> EMG_IRQ)
      else $error("emergency stop without its event");
   a_emg_gate_off: assert property (!emg_en_r && !emg_r |=> !emg_r)
      else $error("emergency stop taken while disabled");
   a_release_refused: assert property (emg_r && (run_r || stm_r != `STM_INIT) |=> emg_r)
      else $error("emergency released while not stopped");
   a_no_restart_emg: assert property (emg_r && st_r == ST_IDLE |=> st_r == ST_IDLE)
      else $error("timer restarted in emergency stop");
   a_period_wrap: assert property (st_r == ST_COUNT && cnt_r == period_r && !freeze && MODE_RUN_OK
      && (run_r || stm_r == `STM_END) |=> PERIOD_IRQ && cnt_r == 0)
      else $error("period wrap without event");
   a_count_in_emg: assert property (emg_r && st_r == ST_COUNT && run_r && !freeze && MODE_RUN_OK
      && cnt_r != period_r |=> cnt_r == $past(cnt_r) + 1'b1)
      else $error("counter stalled by emergency stop");
   a_mode_reset: assert property (!MODE_RUN_OK |=> st_r == ST_IDLE && cnt_r == 0 && !run_r)
      else $error("timer kept running outside normal modes");
   a_break_freeze: assert property (freeze && st_r == ST_COUNT && run_r |=> cnt_r == $past(cnt_r)
      && out_r == init_r)
      else $error("counter or outputs moved during break");
   a_stop_level_wait: assert property (st_r == ST_WAIT_TRIG |-> !PERIOD_IRQ)
      else $error("period event while waiting for trigger");
endmodule

// *** emg_source.sv ***
// far-side model: external emergency stop source on the active-low pin
// assumes one clock shared with the timer; a request of any length gives a low of at least four clocks
`timescale 1ns/1ps
module emg_source (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic low_req,
   output logic      pin_b
);
   logic [2:0] hold_r;
   logic [2:0] hold_nxt;

   // ==========================================
   // stretch every low request by four clocks
   always_comb begin
      hold_nxt = hold_r;
      if (low_req) begin
         hold_nxt = 3'h4;
      end else if (hold_r != 3'h0) begin
         hold_nxt = hold_r - 3'h1;
      end
   end

   // hold counter register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hold_r <= 3'h0;
      end else begin
         hold_r <= hold_nxt;
      end
   end

   // pin is low while requested or held
   assign pin_b = !(low_req || hold_r != 3'h0);
endmodule

// *** pulse_timer_emergency_stop_tb.sv ***
// self-checking bench for the pulse timer with emergency stop
// assumes the package, design and emg_source files compile first
`timescale 1ns/1ps
`include "pulse_timer_cfg.svh"
module pulse_timer_emergency_stop_tb;
   import pulse_timer_pkg::*;
   logic        SYS_CLK           = 1'b0;
   logic        RST_B             = 1'b0;
   logic [3:0]  ADDR              = 4'h0;
   logic [15:0] WR_DATA           = 16'h0000;
   logic        WR_STB            = 1'b0;
   logic        RD_STB            = 1'b0;
   logic [15:0] RD_DATA;
   logic        TRIG_PIN          = 1'b1;
   logic        EMG_PIN_B;
   logic        EMG_PORT_IS_INPUT = 1'b1;
   logic        HF_CLK_RUN        = 1'b1;
   logic        MODE_RUN_OK       = 1'b1;
   logic        DBG_BREAK         = 1'b0;
   logic        DBG_KEEP_RUN      = 1'b0;
   logic [1:0]  PULSE_OUT;
   logic        PERIOD_IRQ;
   logic        TRIG_IRQ;
   logic        EMG_IRQ;
   logic [2:0]  irqs;
   logic        low_req           = 1'b0;
   int          err_count         = 0;
   int          n_tests           = 0;
   int          cyc               = 0;
   int          emg_cnt           = 0;
   int          k;
   int          e0;

   pulse_timer_emergency_stop pulse_timer_emergency_stop_inst (
      .SYS_CLK(SYS_CLK), .RST_B(RST_B), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_STB(WR_STB),
      .RD_STB(RD_STB), .RD_DATA(RD_DATA), .TRIG_PIN(TRIG_PIN), .EMG_PIN_B(EMG_PIN_B),
      .EMG_PORT_IS_INPUT(EMG_PORT_IS_INPUT), .HF_CLK_RUN(HF_CLK_RUN), .MODE_RUN_OK(MODE_RUN_OK),
      .DBG_BREAK(DBG_BREAK), .DBG_KEEP_RUN(DBG_KEEP_RUN), .PULSE_OUT(PULSE_OUT),
      .PERIOD_IRQ(PERIOD_IRQ), .TRIG_IRQ(TRIG_IRQ), .EMG_IRQ(EMG_IRQ));

   emg_source emg_source_inst (.clk(SYS_CLK), .rst_b(RST_B), .low_req(low_req), .pin_b(EMG_PIN_B));

   assign irqs = {EMG_IRQ, TRIG_IRQ, PERIOD_IRQ};

   // ==========================================
   // clock, timeout and emergency event count
   always #25 SYS_CLK = ~SYS_CLK;

   always @(posedge SYS_CLK) begin
      cyc++;
      if (EMG_IRQ === 1'b1) begin
         emg_cnt++;
      end
      if (cyc == 20000) begin
         err_count++;
         print_verdict();
      end
   end

   // ==========================================
   // shared tasks
   task automatic print_verdict();
      if (err_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      ADDR <= a;
      WR_DATA <= d;
      WR_STB <= 1'b1;
      @(posedge SYS_CLK);
      WR_STB <= 1'b0;
      @(posedge SYS_CLK);
   endtask

   task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
      ADDR <= a;
      RD_STB <= 1'b1;
      @(posedge SYS_CLK);
      RD_STB <= 1'b0;
      #1;
      check(RD_DATA, exp);
      @(posedge SYS_CLK);
   endtask

   // edges until the chosen event pulses, 0 when none in n
   task automatic wait_irq(input int i, input int n, output int kk);
      kk = 0;
      for (int c = 1; c <= n && kk == 0; c++) begin
         @(posedge SYS_CLK);
         #1;
         if (irqs[i] === 1'b1) begin
            kk = c;
         end
      end
   endtask

   // ==========================================
   // scenarios
   task automatic t_reset();
      rdchk(`ADDR_CTRL_TWO, 16'h0000);
      rdchk(`ADDR_CTRL_THREE, 16'h0000);
      rdchk(`ADDR_PERIOD, 16'h03ff);
      rdchk(4'hf, 16'h0000);
   endtask

   task automatic t_trig_wait();
      TRIG_PIN <= 1'b0;
      wr(`ADDR_PERIOD, 16'h0004);
      wr(`ADDR_CTRL_THREE, 16'h0001);
      wait_irq(0, 6, k);
      check(16'(k), 16'h0000);
      TRIG_PIN <= 1'b1;
      wait_irq(1, 4, k);
      check(16'(k != 0), 16'h0001);
      wr(`ADDR_CTRL_THREE, 16'h0000);
   endtask

   task automatic t_cmd_start();
      wr(`ADDR_CTRL_ONE, 16'h0002);
      wr(`ADDR_CTRL_THREE, 16'h0001);
      #1;
      check({15'h0, PERIOD_IRQ}, 16'h0001);
      wait_irq(0, 10, k);
      check(16'(k), 16'h0005);
   endtask

   task automatic t_emg_stop();
      wr(`ADDR_CTRL_TWO, 16'h0001);
      low_req <= 1'b1;
      wait_irq(2, 4, k);
      check(16'(k != 0), 16'h0001);
      check({14'h0, PULSE_OUT}, 16'h0002);
      rdchk(`ADDR_CTRL_THREE, 16'h0019);
      wait_irq(0, 6, k);
      check(16'(k != 0), 16'h0001);
      check({14'h0, PULSE_OUT}, 16'h0002);
   endtask

   task automatic t_release();
      wr(`ADDR_CTRL_TWO, 16'h0003);
      rdchk(`ADDR_CTRL_THREE, 16'h0019);
      wr(`ADDR_CTRL_THREE, 16'h0000);
      wr(`ADDR_CTRL_THREE, 16'h0001);
      rdchk(`ADDR_CTRL_THREE, 16'h0009);
      wr(`ADDR_CTRL_THREE, 16'h0000);
      e0 = emg_cnt;
      wr(`ADDR_CTRL_TWO, 16'h0003);
      repeat (3) @(posedge SYS_CLK);
      check(16'(emg_cnt - e0 > 0), 16'h0001);
      rdchk(`ADDR_CTRL_THREE, 16'h0008);
      low_req <= 1'b0;
      repeat (6) @(posedge SYS_CLK);
      wr(`ADDR_CTRL_THREE, 16'h0004);
      wr(`ADDR_CTRL_TWO, 16'h0003);
      rdchk(`ADDR_CTRL_THREE, 16'h000c);
      wr(`ADDR_CTRL_THREE, 16'h0000);
      wr(`ADDR_CTRL_TWO, 16'h0003);
      rdchk(`ADDR_CTRL_THREE, 16'h0000);
      wr(`ADDR_CTRL_ONE, 16'h0002);
      wr(`ADDR_CTRL_THREE, 16'h0001);
      #1;
      check({15'h0, PERIOD_IRQ}, 16'h0001);
      check({14'h0, PULSE_OUT}, 16'h0001);
   endtask

   // pin low must be ignored when disabled, port not input, or fast clock off
   task automatic t_gated();
      logic [2:0] cfg [3];
      cfg = '{3'b011, 3'b101, 3'b110};
      foreach (cfg[i]) begin
         wr(`ADDR_CTRL_TWO, {15'h0, cfg[i][2]});
         EMG_PORT_IS_INPUT <= cfg[i][1];
         HF_CLK_RUN <= cfg[i][0];
         e0 = emg_cnt;
         low_req <= 1'b1;
         repeat (8) @(posedge SYS_CLK);
         low_req <= 1'b0;
         repeat (6) @(posedge SYS_CLK);
         check(16'(emg_cnt - e0), 16'h0000);
      end
      EMG_PORT_IS_INPUT <= 1'b1;
      HF_CLK_RUN <= 1'b1;
   endtask

   task automatic t_break_mode();
      wr(`ADDR_CTRL_ONE, 16'h0001);
      DBG_BREAK <= 1'b1;
      wait_irq(0, 6, k);
      check(16'(k), 16'h0000);
      check({14'h0, PULSE_OUT}, 16'h0001);
      DBG_KEEP_RUN <= 1'b1;
      wait_irq(0, 6, k);
      check(16'(k != 0), 16'h0001);
      check({14'h0, PULSE_OUT}, 16'h0002);
      DBG_BREAK <= 1'b0;
      DBG_KEEP_RUN <= 1'b0;
      wait_irq(0, 8, k);
      check(16'(k != 0), 16'h0001);
      MODE_RUN_OK <= 1'b0;
      repeat (2) @(posedge SYS_CLK);
      MODE_RUN_OK <= 1'b1;
      rdchk(`ADDR_CTRL_THREE, 16'h0000);
      wr(`ADDR_CTRL_THREE, 16'h0000);
      MODE_RUN_OK <= 1'b0;
      repeat (2) @(posedge SYS_CLK);
      MODE_RUN_OK <= 1'b1;
      wr(`ADDR_CTRL_ONE, 16'h0000);
      wr(`ADDR_CTRL_TWO, 16'h0000);
      wr(`ADDR_CTRL_THREE, 16'h0001);
      #1;
      check({15'h0, PERIOD_IRQ}, 16'h0001);
      check({14'h0, PULSE_OUT}, 16'h0003);
   endtask

   // ==========================================
   // main sequence
   initial begin
      repeat (12) @(posedge SYS_CLK);
      RST_B <= 1'b1;
      @(posedge SYS_CLK);
      t_reset();
      t_trig_wait();
      t_cmd_start();
      t_emg_stop();
      t_release();
      t_gated();
      t_break_mode();
      print_verdict();
   end
endmodule
